// File: core/dact_node_map.v
`include "dact_regs.vh"
// ==========================================================
// node lookup: kind and port of a node id under a layout
module dact_node_map (
	// layout
	input  wire       alt_layout,
	input  wire [7:0] ctl,
	// query
	input  wire [7:0] node,
	output reg  [2:0] kind,
	output reg  [2:0] port,
	output reg  [2:0] pin_idx
);
	wire [1:0] wl = ctl[`DACT_CTL_WL_HI:`DACT_CTL_WL_LO];
	wire       all = ctl[`DACT_CTL_ALL];
	wire       fourth = ctl[`DACT_CTL_FOURTH];
	wire [2:0] sel_a = ctl[`DACT_CTL_SEL_HI:`DACT_CTL_SEL_LO];
	wire [1:0] sel_b = ctl[`DACT_CTL_SEL_HI:`DACT_CTL_SEL2_LO];

	// layout tables; unlisted ids answer as absent
	always @* begin
		kind = `DACT_KIND_NONE;
		port = `DACT_PORT_B;
		pin_idx = 3'h0;
		if (node == `DACT_NODE_ROOT)
			kind = `DACT_KIND_ROOT;
		else if (node == `DACT_NODE_FUNC)
			kind = `DACT_KIND_ROOT;
		else if (!alt_layout) begin
			if (node == `DACT_NODE_VEND_A)
				kind = `DACT_KIND_VEND;
			else if (!all) begin
				// port select ignored once bit 0 is set
				if (node == 8'h03)
					kind = `DACT_KIND_CONV;
				else if (node == 8'h04 && sel_a <= `DACT_PORT_F) begin
					kind = `DACT_KIND_PIN;
					port = sel_a;
				end
			end else if (node >= 8'h03 && node <= 8'h0A) begin
				// odd ids convert, even ids are pins B..E
				kind = node[0] ? `DACT_KIND_CONV : `DACT_KIND_PIN;
				port = node[3:1] - 3'h2;
				pin_idx = node[3:1] - 3'h2;
			end else if (node == 8'h0B) begin
				kind = `DACT_KIND_PIN;
				port = `DACT_PORT_F;
				pin_idx = 3'h4;
			end else if (node == `DACT_NODE_WL1 && wl != 2'b00 && wl != 2'b11)
				kind = `DACT_KIND_WL;
			else if (node == `DACT_NODE_WL2 && wl == 2'b10)
				kind = `DACT_KIND_WL;
		end else begin
			if (node == `DACT_NODE_VEND_B)
				kind = `DACT_KIND_VEND;
			else if (node == 8'h02)
				kind = `DACT_KIND_CONV;
			else if (!all) begin
				if (node == 8'h03) begin
					kind = `DACT_KIND_PIN;
					if (sel_b == 2'b11)
						port = `DACT_PORT_F;
					else
						port = {1'b0, sel_b};
					if (sel_b == 2'b11 && !fourth)
						kind = `DACT_KIND_NONE;
				end
			end else if (node == 8'h03 || node == 8'h04)
				kind = `DACT_KIND_CONV;
			else if (node >= 8'h05 && node <= 8'h07) begin
				kind = `DACT_KIND_PIN;
				port = node[2:0] - 3'h5;
				pin_idx = node[2:0] - 3'h5;
			end else if (node == 8'h08 && fourth) begin
				kind = `DACT_KIND_PIN;
				port = `DACT_PORT_F;
				pin_idx = 3'h3;
			end else if (node >= 8'h08 && node <= 8'h0A && wl != 2'b00) begin
				// wireless widgets follow the last pin
				if (node == (fourth ? 8'h09 : 8'h08))
					kind = `DACT_KIND_WL;
				else if (wl == 2'b10 && node == (fourth ? 8'h0A : 8'h09))
					kind = `DACT_KIND_WL;
			end
		end
	end
endmodule

// File: core/dact_regs.vh
`ifndef DACT_REGS_VH
`define DACT_REGS_VH
// ==========================================================
// verb ids (12-bit)
`define DACT_VERB_GET_PARAM   12'hF00
`define DACT_VERB_SET_CTL     12'h781
`define DACT_VERB_GET_CTL     12'hF81
`define DACT_VERB_CFG_B0      12'h71C
`define DACT_VERB_CFG_B3      12'h71F
`define DACT_VERB_GET_CFG     12'hF1C
`define DACT_VERB_GET_DEVLIST 12'hF36
`define DACT_VERB_GTC_B0      12'h785
`define DACT_VERB_GTC_B3      12'h788
`define DACT_VERB_GET_GTC     12'hF85
// ==========================================================
// layout control byte fields
`define DACT_CTL_ALL          0
`define DACT_CTL_MST          1
`define DACT_CTL_WL_HI        3
`define DACT_CTL_WL_LO        2
`define DACT_CTL_FOURTH       4
`define DACT_CTL_SEL_HI       7
`define DACT_CTL_SEL_LO       5
`define DACT_CTL_SEL2_LO      6
`define DACT_CTL_RESET        8'h00
`define DACT_WORD_RESET       32'h0000_0000
// ==========================================================
// node ids
`define DACT_NODE_ROOT        8'h00
`define DACT_NODE_FUNC        8'h01
`define DACT_NODE_VEND_A      8'h02
`define DACT_NODE_VEND_B      8'h0B
`define DACT_NODE_WL1         8'h0C
`define DACT_NODE_WL2         8'h0D
// node kinds reported by lookup
`define DACT_KIND_NONE        3'h0
`define DACT_KIND_CONV        3'h1
`define DACT_KIND_PIN         3'h2
`define DACT_KIND_VEND        3'h3
`define DACT_KIND_WL          3'h4
`define DACT_KIND_ROOT        3'h5
// port codes
`define DACT_PORT_B           3'h0
`define DACT_PORT_C           3'h1
`define DACT_PORT_D           3'h2
`define DACT_PORT_E           3'h3
`define DACT_PORT_F           3'h4
`define DACT_RESP_NONE        32'h0000_0000
`endif

// File: core/dact_topology.v
`include "dact_regs.vh"
// What this block does
// - At most one verb is taken per link frame.
// - One codec answers for every converter and pin node.
// - Node-02h layout ignores port select while bit 0 is set.
// - Node-02h layout, bit 0 set: converters 3,5,7,9, pins 4,6,8,A,B, any routing.
// - Bits 1 and 0 set enable multistream on the pins.
// - Bits 3:2 expose zero, one or two wireless widgets.
// - Node-0Bh layout, bit 0 only: pins B,C,D at 5,6,7 fixed 1:1.
// - Node-0Bh layout, bits 0 and 1: any routing plus multistream.
// - Node-0Bh layout, bit 4 with bit 0: port F pin at node 8.
// - Time offset written as four bytes 785h..788h, read on F85h.
// - Pin config default written as bytes 71Ch..71Fh, read on F1Ch.
// - Pins answer F36h with entries of their device list.
module dact_topology #(
	parameter ALT_LAYOUT = 0,
	parameter NUM_PINS   = 5,
	parameter DEVLIST_N  = 4
) (
	// clock and reset
	input  wire        ref_clk,
	input  wire        reset,
	// link frame and verb
	input  wire        frame_sync,
	input  wire        verb_valid,
	input  wire [7:0]  verb_node,
	input  wire [11:0] verb_id,
	input  wire [7:0]  verb_payload,
	// response
	output reg         resp_valid,
	output reg  [31:0] resp_data,
	// layout state
	output reg  [7:0]  codec_topology_control,
	output reg         multistream_on,
	output reg         any_routing_on,
	output reg  [31:0] global_time_count
);
	// ==========================================================
	// decode
	wire [2:0] kind;
	wire [2:0] port;
	wire [2:0] pin_idx;
	reg        frame_used;
	reg [31:0] cfg_default [0:NUM_PINS-1];
	reg [31:0] devlist     [0:DEVLIST_N-1];
	integer    i;

	dact_node_map u_map (
		.alt_layout (ALT_LAYOUT != 0),
		.ctl        (codec_topology_control),
		.node       (verb_node),
		.kind       (kind),
		.port       (port),
		.pin_idx    (pin_idx)
	);

	// one verb per frame; extras in the same frame are dropped
	wire take = verb_valid && (!frame_used || frame_sync);
	wire is_vend = (kind == `DACT_KIND_VEND);
	wire is_pin  = (kind == `DACT_KIND_PIN);
	wire cfg_wr  = is_pin && verb_id >= `DACT_VERB_CFG_B0 && verb_id <= `DACT_VERB_CFG_B3;
	wire gtc_wr  = is_vend && verb_id >= `DACT_VERB_GTC_B0 && verb_id <= `DACT_VERB_GTC_B3;
	wire [1:0] cfg_lane = verb_id[1:0];
	wire [1:0] gtc_lane = verb_id[1:0] - 2'h1;
	wire [7:0] next_ctl = verb_payload;

	// ==========================================================
	// verb execution
	always @(posedge ref_clk) begin
		if (reset) begin
			frame_used <= 1'b0;
			resp_valid <= 1'b0;
			resp_data <= `DACT_RESP_NONE;
			codec_topology_control <= `DACT_CTL_RESET;
			multistream_on <= 1'b0;
			any_routing_on <= 1'b0;
			global_time_count <= `DACT_WORD_RESET;
			for (i = 0; i < NUM_PINS; i = i + 1)
				cfg_default[i] <= `DACT_WORD_RESET;
			for (i = 0; i < DEVLIST_N; i = i + 1)
				devlist[i] <= `DACT_WORD_RESET;
		end else begin
			resp_valid <= 1'b0;
			if (frame_sync)
				frame_used <= take;
			else if (take)
				frame_used <= 1'b1;
			// multistream only with all pins on
			multistream_on <= codec_topology_control[`DACT_CTL_ALL] &&
				codec_topology_control[`DACT_CTL_MST];
			any_routing_on <= codec_topology_control[`DACT_CTL_ALL] &&
				(ALT_LAYOUT == 0 || codec_topology_control[`DACT_CTL_MST] ||
				codec_topology_control[`DACT_CTL_FOURTH]);
			if (take) begin
				// every reachable node answers; absent nodes answer zero, except hidden node 3 of the node-0Bh layout, which reports port F on F00h
				resp_valid <= 1'b1;
				resp_data <= `DACT_RESP_NONE;
				if (is_vend && verb_id == `DACT_VERB_SET_CTL)
					codec_topology_control <= next_ctl;
				else if (is_vend && verb_id == `DACT_VERB_GET_CTL)
					resp_data <= {24'h000000, codec_topology_control};
				else if (gtc_wr)
					global_time_count[gtc_lane*8 +: 8] <= verb_payload;
				else if (is_vend && verb_id == `DACT_VERB_GET_GTC)
					resp_data <= global_time_count;
				else if (cfg_wr)
					cfg_default[pin_idx][cfg_lane*8 +: 8] <= verb_payload;
				else if (is_pin && verb_id == `DACT_VERB_GET_CFG)
					resp_data <= cfg_default[pin_idx];
				else if (is_pin && verb_id == `DACT_VERB_GET_DEVLIST)
					resp_data <= devlist[verb_payload[1:0]];
				else if (verb_id == `DACT_VERB_GET_PARAM)
					resp_data <= {26'h0, kind, port};
			end
		end
	end
endmodule

// File: verif/dact_ctl_model.sv
module dact_ctl_model (
	// clock, reset and bench request
	input  wire         ref_clk,
	input  wire         reset,
	input  wire         req,
	input  wire         dbl,
	input  wire  [7:0]  node,
	input  wire  [11:0] id,
	input  wire  [7:0]  pl,
	// link toward the codec
	output logic        frame_sync,
	output logic        verb_valid,
	output logic [7:0]  verb_node,
	output logic [11:0] verb_id,
	output logic [7:0]  verb_payload
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] cnt = 3'h0;
	logic       sec = 1'h0;
	// extra slot exists only to provoke a refusal
	wire first  = !reset && req && cnt == 3'h7;
	wire second = !reset && sec && cnt == 3'h1;
	initial {frame_sync, verb_valid, verb_node, verb_id, verb_payload} = '0;
	// frame timer; idle lines toggle so stale data never looks valid
	always @(posedge ref_clk) begin
		cnt        <= reset ? 3'h0 : cnt + 3'h1;
		frame_sync <= !reset && cnt == 3'h7;
		verb_valid <= first || second;
		sec        <= first ? dbl : (cnt == 3'h1 ? 1'h0 : sec);
		if (first || second)
			{verb_node, verb_id, verb_payload} <= {node, id, second ? ~pl : pl};
		else
			{verb_node, verb_id, verb_payload} <= ~{verb_node, verb_id, verb_payload};
	end
endmodule

// File: verif/dact_topology_properties.sv
module dact_topology_properties (
	// clock and reset
	input wire        ref_clk,
	input wire        reset,
	// verb in
	input wire        frame_sync,
	input wire        verb_valid,
	input wire [7:0]  verb_node,
	input wire [11:0] verb_id,
	input wire [7:0]  verb_payload,
	// answers and state
	input wire        resp_valid,
	input wire [31:0] resp_data,
	input wire [7:0]  codec_topology_control,
	input wire        multistream_on,
	input wire        any_routing_on,
	input wire [31:0] global_time_count
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	// vendor node verb at a frame start, always taken
	wire vend = verb_valid && frame_sync && verb_node == 8'h02;
	property p_ans; verb_valid && frame_sync |=> resp_valid; endproperty
	a_ans: assert property (p_ans) else $error("no answer");
	property p_one; resp_valid |-> $past(verb_valid); endproperty
	a_one: assert property (p_one) else $error("stray answer");
	property p_ref; (frame_sync && verb_valid) ##1 !frame_sync ##1 (verb_valid && !frame_sync)
		|=> !resp_valid; endproperty
	a_ref: assert property (p_ref) else $error("second verb answered");
	property p_mst; multistream_on == ($past(codec_topology_control[1:0]) == 2'h3); endproperty
	a_mst: assert property (p_mst) else $error("multistream wrong");
	property p_any; any_routing_on == $past(codec_topology_control[0]); endproperty
	a_any: assert property (p_any) else $error("routing wrong");
	property p_set; vend && verb_id == 12'h781 |=> codec_topology_control == $past(verb_payload);
	endproperty
	a_set: assert property (p_set) else $error("layout not set");
	property p_gtc; vend && verb_id == 12'h785 |=> global_time_count[7:0] == $past(verb_payload);
	endproperty
	a_gtc: assert property (p_gtc) else $error("offset byte lost");
	property p_hold; !resp_valid |-> $stable(resp_data); endproperty
	a_hold: assert property (p_hold) else $error("answer moved");
endmodule
bind dact_topology dact_topology_properties i_props (.*);

// File: verif/dact_topology_test.sv
module dact_topology_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic        ref_clk = 1'h0, reset = 1'h1, req = 1'h0, dbl = 1'h0;
	logic        frame_sync, verb_valid, resp_valid, multistream_on, any_routing_on;
	logic [7:0]  node = 8'h00, pl = 8'h00, verb_node, verb_payload, codec_topology_control;
	logic [11:0] id = 12'h000, verb_id;
	logic [31:0] resp_data, global_time_count, d;
	int          num_errors = 0, num_checks = 0;
	dact_topology i_dact_topology (.*);
	dact_ctl_model i_dact_ctl_model (.*);
	// 100 MHz clock
	initial forever #5 ref_clk = ~ref_clk;
	task automatic chk(string s, logic [31:0] e, logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic verb(logic [7:0] n, logic [11:0] v, logic [7:0] p);
		int k = 0;
		{node, id, pl, req} <= {n, v, p, 1'h1};
		do begin
			@(posedge ref_clk);
			k++;
		end while (!verb_valid && k < 30);
		req <= 1'h0;
		if (!verb_valid) begin
			num_errors++;
			end_sim();
		end
		#1 chk("answer", 32'h1, {31'h0, resp_valid});
		d = resp_data;
		@(posedge ref_clk);
	endtask
	task automatic t_ctl();
		logic [7:0] c [4] = '{8'h62, 8'h03, 8'hE1, 8'h09};
		for (int i = 0; i < 4; i++) begin
			verb(8'h02, 12'h781, c[i]);
			verb(8'h02, 12'hF81, 8'h00);
			chk("layout", {24'h0, c[i]}, d);
			chk("mst any", {30'h0, &c[i][1:0], c[i][0]}, {30'h0, multistream_on, any_routing_on});
			verb(8'h0D, 12'hF00, 8'h00);
			chk("wireless", (c[i][3:2] == 2'b10) ? 32'h20 : 32'h0, d);
			verb(8'h04, 12'hF00, 8'h00);
			chk("port", 32'h10 | (c[i][0] ? 32'h0 : {29'h0, c[i][7:5]}), d);
		end
		$display("done layout");
	endtask
	task automatic t_bytes();
		verb(8'h02, 12'h781, 8'h01);
		for (int i = 0; i < 4; i++) begin
			verb(8'h02, 12'h785 + 12'(i), 8'h11 * 8'(i + 1));
			verb(8'h04, 12'h71C + 12'(i), 8'hAA + 8'h11 * 8'(i));
		end
		verb(8'h02, 12'hF85, 8'h00);
		chk("offset", 32'h44332211, d);
		chk("offset out", 32'h44332211, global_time_count);
		verb(8'h04, 12'hF1C, 8'h00);
		chk("pin cfg", 32'hDDCCBBAA, d);
		verb(8'h04, 12'hF36, 8'h00);
		chk("dev list", 32'h0, d);
		$display("done bytes");
	endtask
	task automatic t_dbl();
		dbl <= 1'h1;
		verb(8'h02, 12'h781, 8'h5A);
		dbl <= 1'h0;
		@(posedge ref_clk);
		#1 chk("refused", 32'h0, {31'h0, resp_valid});
		@(posedge ref_clk);
		verb(8'h02, 12'hF81, 8'h00);
		chk("kept", 32'h5A, d);
		$display("done refusal");
	endtask
	// reset for ten cycles, then the scenarios
	initial begin
		repeat (10) @(posedge ref_clk);
		reset <= 1'h0;
		t_ctl();
		t_bytes();
		t_dbl();
		end_sim();
	end
endmodule
